/* hdl/cog_clock_control.sv */
// Purpose: power-up, power-down and stop gating of the clock outputs
// Assumes: raw clock phases come from the synthesizer on this clock
// Notes:   registers reached through a byte port of the serial engine
//
// What this block does
// - three-bit slew per single-ended output; bits 2,0 in byte 13 reset one.
// - slew code 000 strongest, 111 weakest; normal default is 101.
// - byte 13 bit 0 low-emission; 1 loads codes 111, 0 loads 101.
// - byte 14 bits 4:0 read back the factory programming identity.
// - pin is supply-good until first sampled high, then power-down low.
// - power-down input synchronised; clocks held low before oscillators stop.
// - after power-down sampled low, differential outputs stop low/low within two edges.
// - after two low samples, single-ended outputs held low from next fall.
// - ready to sample the pin within 2 ms crystal, 8 ms differential.
// - within 1.8 ms of rising pin, lock, then enable outputs glitch-free.
// - pair-stop gates only pairs two and three; everything else runs.
// - stopped pairs park true leg high, complement leg low.
// - stopped pairs resume without short or stretched pulses.
// - stopped pairs active again within two of their own cycles.
// - power-down: differential legs low; single-ended low, or high-z if strapped.
// - each stoppable pair has a register enable, reset enabled.
`timescale 1ns/1ps
module cog_clock_control #(
  parameter int unsigned LOCK_WAIT    = cog_pkg::LOCK_CYCLES,
  parameter int unsigned XTAL_STARTUP = cog_pkg::XTAL_UP_CYCLES,
  parameter int unsigned DIFF_STARTUP = cog_pkg::DIFF_UP_CYCLES
) (
  input  wire logic                          clock,
  input  wire logic                          rstn,
  input  wire cog_pkg::cog_pins_t            pins,
  input  wire logic [cog_pkg::DIFF_COUNT-1:0] diffPhase,
  input  wire logic [cog_pkg::SE_COUNT-1:0]   sePhase,
  input  wire logic [7:0]                    regAddr,
  input  wire logic [7:0]                    regWrData,
  input  wire logic                          regWrEn,
  output logic [7:0]                         regRdData,
  output logic [cog_pkg::DIFF_COUNT-1:0]     diffTrue,
  output logic [cog_pkg::DIFF_COUNT-1:0]     diffComp,
  output logic [cog_pkg::SE_COUNT-1:0]       seOut,
  output logic [cog_pkg::SE_COUNT-1:0]       seOutEn,
  output logic                               oscEnable,
  output logic                               pllEnable,
  output logic                               pinReady,
  output cog_pkg::cog_slew_t                 slew
);
  import cog_pkg::*;

  localparam int unsigned PIN_COUNT = 4;

  cog_state_t              state;
  logic [PIN_COUNT-1:0]    pinsSync;
  logic                    pinLevel;
  logic                    pairStopN;
  logic                    strapSync;
  logic                    diffRefSync;
  logic [CNT_W-1:0]        waitCount;
  logic [1:0]              lowSamples;
  logic                    diffGateOff;
  logic                    seGateOff;
  logic [DIFF_COUNT-1:0]   diffHeld;
  logic [DIFF_COUNT-1:0]   diffParked;
  logic [SE_COUNT-1:0]     seHeld;
  logic [7:0]              pairEnable;
  logic [7:0]              slewMid;
  logic [7:0]              slewControl;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // every control pin is asynchronous to the reference clock
  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : gSync
      cog_sync2 uSync (
        .clock   (clock),
        .rstn    (rstn),
        .asyncIn (pins[i]),
        .syncOut (pinsSync[i])
      );
    end
  endgenerate

  assign pinLevel    = pinsSync[3];
  assign pairStopN   = pinsSync[2];
  assign strapSync   = pinsSync[1];
  assign diffRefSync = pinsSync[0];

  ////////////////////////////////////////////////////////////////////////
  // power sequencing

  // startup waits the longer allowance when a differential reference is
  // used; the pin is ignored until then so a slow supply cannot glitch it
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state     <= ST_STARTUP;
      waitCount <= '0;
    end else begin
      unique case (state)
        ST_STARTUP: begin
          if ((!diffRefSync && waitCount >= CNT_W'(XTAL_STARTUP - 1)) ||
              (diffRefSync && waitCount >= CNT_W'(DIFF_STARTUP - 1))) begin
            state     <= ST_WAIT;
            waitCount <= '0;
          end else begin
            waitCount <= waitCount + 1'b1;
          end
        end
        ST_WAIT: begin
          if (pinLevel) begin
            state     <= ST_LOCK;
            waitCount <= '0;
          end
        end
        ST_LOCK: begin
          if (!pinLevel) begin
            state     <= ST_DOWN;
          end else if (waitCount >= CNT_W'(LOCK_WAIT - 1)) begin
            state     <= ST_RUN;
            waitCount <= '0;
          end else begin
            waitCount <= waitCount + 1'b1;
          end
        end
        ST_RUN: begin
          if (!pinLevel) begin
            state <= ST_DOWN;
          end
        end
        ST_DOWN: begin
          if (pinLevel) begin
            state     <= ST_LOCK;
            waitCount <= '0;
          end
        end
      endcase
    end
  end

  // count consecutive low samples for the single-ended stop
  always_ff @(posedge clock) begin
    if (!rstn) begin
      lowSamples <= 2'h0;
    end else if (pinLevel) begin
      lowSamples <= 2'h0;
    end else if (lowSamples != 2'h2) begin
      lowSamples <= lowSamples + 2'h1;
    end
  end

  // gates: differential after one low sample, single-ended after two
  always_ff @(posedge clock) begin
    if (!rstn) begin
      diffGateOff <= 1'b1;
      seGateOff   <= 1'b1;
    end else begin
      diffGateOff <= (state != ST_RUN) || !pinLevel;
      seGateOff   <= (state != ST_RUN) || (lowSamples == 2'h2);
    end
  end

  // oscillators go off only once every output is already held low
  always_ff @(posedge clock) begin
    if (!rstn) begin
      oscEnable <= 1'b0;
      pllEnable <= 1'b0;
      pinReady  <= 1'b0;
    end else begin
      oscEnable <= (state == ST_LOCK) || (state == ST_RUN) ||
                   ((state == ST_DOWN) &&
                   !(&diffHeld && &seHeld));
      pllEnable <= (state == ST_LOCK) || (state == ST_RUN) ||
                   ((state == ST_DOWN) && !(&diffHeld && &seHeld));
      pinReady  <= (state != ST_STARTUP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // differential output gating

  // a hold engages or releases only when the phase already matches the
  // held level, so no pulse is ever cut short or stretched
  generate
    for (genvar d = 0; d < DIFF_COUNT; d++) begin : gDiff
      logic stopWanted;
      logic parkWanted;
      if (d >= STOP_FIRST) begin : gStoppable
        assign stopWanted = diffGateOff || !pairEnable[d];
        assign parkWanted = !pairStopN;
      end else begin : gFree
        assign stopWanted = diffGateOff;
        assign parkWanted = 1'b0;
      end

      // low/low hold, entered on a low phase
      always_ff @(posedge clock) begin
        if (!rstn) begin
          diffHeld[d] <= 1'b1;
        end else if (stopWanted && !diffPhase[d]) begin
          diffHeld[d] <= 1'b1;
        end else if (!stopWanted && !diffPhase[d]) begin
          diffHeld[d] <= 1'b0;
        end
      end

      // high/low park, entered and left on a high phase
      always_ff @(posedge clock) begin
        if (!rstn) begin
          diffParked[d] <= 1'b0;
        end else if (diffPhase[d]) begin
          diffParked[d] <= parkWanted;
        end
      end

      // legs; power-down and register disable win over the park
      always_ff @(posedge clock) begin
        if (!rstn) begin
          diffTrue[d] <= 1'b0;
          diffComp[d] <= 1'b0;
        end else if (diffHeld[d] || (stopWanted && !diffPhase[d])) begin
          diffTrue[d] <= 1'b0;
          diffComp[d] <= 1'b0;
        end else if (diffParked[d] || (parkWanted && diffPhase[d])) begin
          diffTrue[d] <= 1'b1;
          diffComp[d] <= 1'b0;
        end else begin
          diffTrue[d] <= diffPhase[d];
          diffComp[d] <= !diffPhase[d];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // single-ended output gating

  generate
    for (genvar s = 0; s < SE_COUNT; s++) begin : gSe
      // held from the next falling transition, released on a low phase
      always_ff @(posedge clock) begin
        if (!rstn) begin
          seHeld[s] <= 1'b1;
        end else if (!sePhase[s]) begin
          seHeld[s] <= seGateOff;
        end
      end

      // strapped parts float their single-ended pins while down
      always_ff @(posedge clock) begin
        if (!rstn) begin
          seOut[s]   <= 1'b0;
          seOutEn[s] <= 1'b1;
        end else begin
          seOut[s]   <= !seHeld[s] && !(seGateOff && !sePhase[s]) &&
                        sePhase[s];
          seOutEn[s] <= !(strapSync && (state != ST_RUN));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // registers

  // pair enables, reset enabled
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pairEnable <= PAIR_ENABLE_RESET;
    end else if (regWrEn && regAddr == PAIR_ENABLE_OFFSET) begin
      pairEnable <= regWrData & PAIR_ENABLE_MASK;
    end
  end

  // changing the low-emission bit reloads every slew code, which is why
  // the middle bits live with the outer ones in this process pair
  always_ff @(posedge clock) begin
    if (!rstn) begin
      slewControl <= SLEW_CONTROL_RESET;
    end else if (regWrEn && regAddr == SLEW_CONTROL_OFFSET) begin
      if (regWrData[LOW_EMISSION_BIT] != slewControl[LOW_EMISSION_BIT]) begin
        slewControl <= regWrData[LOW_EMISSION_BIT] ?
                       SLEW_CONTROL_MASK : SLEW_CONTROL_RESET;
      end else begin
        slewControl <= regWrData & SLEW_CONTROL_MASK;
      end
    end
  end

  // middle slew bits; normal default leaves them clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      slewMid <= SLEW_MID_RESET;
    end else if (regWrEn && regAddr == SLEW_CONTROL_OFFSET &&
                 regWrData[LOW_EMISSION_BIT] !=
                 slewControl[LOW_EMISSION_BIT]) begin
      slewMid <= regWrData[LOW_EMISSION_BIT] ?
                 SLEW_MID_MASK : SLEW_MID_RESET;
    end else if (regWrEn && regAddr == SLEW_MID_OFFSET) begin
      slewMid <= regWrData & SLEW_MID_MASK;
    end
  end

  // effective codes, 000 strongest to 111 weakest
  always_ff @(posedge clock) begin
    if (!rstn) begin
      slew <= {SLEW_NORMAL_CODE, SLEW_NORMAL_CODE, SLEW_NORMAL_CODE};
    end else begin
      slew.refclk <= {slewControl[REF_SLEW_HIGH_BIT],
                      slewMid[REF_SLEW_MID_BIT],
                      slewControl[REF_SLEW_LOW_BIT]};
      slew.video  <= {slewControl[VID_SLEW_HIGH_BIT],
                      slewMid[VID_SLEW_MID_BIT],
                      slewControl[VID_SLEW_LOW_BIT]};
      slew.prog   <= {slewControl[PROG_SLEW_HIGH_BIT],
                      slewMid[PROG_SLEW_MID_BIT],
                      slewControl[PROG_SLEW_LOW_BIT]};
    end
  end

  // read port; unmapped bytes read zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else begin
      unique case (regAddr)
        PAIR_ENABLE_OFFSET:  regRdData <= pairEnable;
        SLEW_MID_OFFSET:     regRdData <= slewMid;
        SLEW_CONTROL_OFFSET: regRdData <= slewControl;
        IDENTITY_OFFSET:     regRdData <= {IDENTITY_HIGH,
                                FACTORY_PROGRAM_ID_DEFAULT};
        default:             regRdData <= 8'h00;
      endcase
    end
  end

endmodule : cog_clock_control

/* hdl/cog_sync2.sv */
// Purpose: two-flop synchroniser for the asynchronous control pins
// Assumes: inputs are levels, slow against the clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module cog_sync2 (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic firstStage;

  // the reset value is high so pins read as idle until really sampled
  always_ff @(posedge clock) begin
    if (!rstn) begin
      firstStage <= 1'b1;
      syncOut    <= 1'b1;
    end else begin
      firstStage <= asyncIn;
      syncOut    <= firstStage;
    end
  end
endmodule : cog_sync2

/* inc/cog_pkg.sv */
// Purpose: shared constants and types for the clock output gating block
// Assumes: one 250 MHz clock; byte-wide register port from the serial engine
// Notes:   times are kept in ns and turned into cycle counts here
package cog_pkg;

  // clock rate
  localparam int unsigned CLK_PERIOD_NS   = 4;

  // documented times, in ns, as printed
  localparam int unsigned LOCK_TIME_NS    = 1800000; // 1.8 ms
  localparam int unsigned XTAL_UP_TIME_NS = 2000000; // 2 ms
  localparam int unsigned DIFF_UP_TIME_NS = 8000000; // 8 ms

  // longest times round down to whole cycles
  localparam int unsigned LOCK_CYCLES    = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned XTAL_UP_CYCLES = XTAL_UP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned DIFF_UP_CYCLES = DIFF_UP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 22;

  // register offsets
  localparam logic [7:0] PAIR_ENABLE_OFFSET  = 8'h04;
  localparam logic [7:0] SLEW_MID_OFFSET     = 8'h06;
  localparam logic [7:0] SLEW_CONTROL_OFFSET = 8'h0d;
  localparam logic [7:0] IDENTITY_OFFSET     = 8'h0e;

  // field positions
  localparam int unsigned PAIR_TWO_EN_BIT    = 2;
  localparam int unsigned PAIR_THREE_EN_BIT  = 3;
  localparam int unsigned REF_SLEW_HIGH_BIT  = 7;
  localparam int unsigned REF_SLEW_LOW_BIT   = 6;
  localparam int unsigned VID_SLEW_HIGH_BIT  = 5;
  localparam int unsigned VID_SLEW_LOW_BIT   = 4;
  localparam int unsigned PROG_SLEW_HIGH_BIT = 3;
  localparam int unsigned PROG_SLEW_LOW_BIT  = 2;
  localparam int unsigned LOW_EMISSION_BIT   = 0;
  localparam int unsigned REF_SLEW_MID_BIT   = 5;
  localparam int unsigned VID_SLEW_MID_BIT   = 3;
  localparam int unsigned PROG_SLEW_MID_BIT  = 1;

  // reset values and write masks
  localparam logic [7:0] PAIR_ENABLE_RESET  = 8'h0c;
  localparam logic [7:0] SLEW_MID_RESET     = 8'h00;
  localparam logic [7:0] SLEW_CONTROL_RESET = 8'hfc;
  localparam logic [2:0] IDENTITY_HIGH      = 3'h5;   // reserved bits 7:5
  localparam logic [7:0] PAIR_ENABLE_MASK   = 8'h0c;
  localparam logic [7:0] SLEW_MID_MASK      = 8'h2a;
  localparam logic [7:0] SLEW_CONTROL_MASK  = 8'hfd;

  // slew codes
  localparam logic [2:0] SLEW_NORMAL_CODE = 3'h5;
  localparam logic [2:0] SLEW_WEAK_CODE   = 3'h7;

  // arbitrary neutral value, not a real programming code
  localparam logic [4:0] FACTORY_PROGRAM_ID_DEFAULT = 5'h15;

  // output counts
  localparam int unsigned DIFF_COUNT  = 4;
  localparam int unsigned SE_COUNT    = 3;
  localparam int unsigned STOP_FIRST  = 2; // pairs two and three stoppable

  typedef enum logic [2:0] {
    ST_STARTUP = 3'b000,
    ST_WAIT    = 3'b001,
    ST_LOCK    = 3'b010,
    ST_RUN     = 3'b011,
    ST_DOWN    = 3'b100
  } cog_state_t;

  // asynchronous control pins
  typedef struct packed {
    logic supplyGoodPowerDownN; // supply_good_strobe then power_down_n
    logic pairStopN;
    logic seHizStrap;
    logic diffReference;        // 1 = differential input reference
  } cog_pins_t;

  // effective three-bit slew codes
  typedef struct packed {
    logic [2:0] refclk;
    logic [2:0] video;
    logic [2:0] prog;
  } cog_slew_t;

endpackage : cog_pkg

/* sim/cog_clock_control_chk.sv */
// Purpose: port checks on the clock output gating block
// Assumes: host phases toggle every one or two cycles
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module cog_clock_control_chk #(
  parameter int unsigned XTAL_STARTUP = 10,
  parameter int unsigned DIFF_STARTUP = 30
) (
  input wire logic                           clock,
  input wire logic                           rstn,
  input wire cog_pkg::cog_pins_t             pins,
  input wire logic [7:0]                     regAddr,
  input wire logic [7:0]                     regRdData,
  input wire logic [cog_pkg::DIFF_COUNT-1:0] diffTrue,
  input wire logic [cog_pkg::DIFF_COUNT-1:0] diffComp,
  input wire logic [cog_pkg::SE_COUNT-1:0]   seOut,
  input wire logic                           oscEnable,
  input wire logic                           pllEnable,
  input wire logic                           pinReady
);
  import cog_pkg::*;
  logic [15:0] upCnt;
  ////////////////////////////////////////////////////////////////////////
  // cycles since reset release, saturating so it never wraps
  always_ff @(posedge clock) begin
    if (!rstn) upCnt <= 16'h0;
    else if (upCnt != 16'hffff) upCnt <= upCnt + 16'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_id_read;
    regAddr == IDENTITY_OFFSET |=>
      regRdData == {IDENTITY_HIGH, FACTORY_PROGRAM_ID_DEFAULT};
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("identity byte read wrong");
  property p_enable_reserved;
    regAddr == PAIR_ENABLE_OFFSET |=> (regRdData & ~PAIR_ENABLE_MASK) == 8'h0;
  endproperty
  a_enable_reserved: assert property (p_enable_reserved)
    else $error("pair enable byte shows reserved bits");
  property p_pin_ignored;
    !pinReady |-> !pllEnable;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored)
    else $error("pll started before the pin was ready");
  property p_ready_time;
    $rose(pinReady) |-> upCnt >= 16'(XTAL_STARTUP) &&
      upCnt <= 16'(DIFF_STARTUP + 4);
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("pin ready at wrong time");
  property p_lock_quiet;
    $rose(pllEnable) |-> (diffTrue == '0 && diffComp == '0) [*8];
  endproperty
  a_lock_quiet: assert property (p_lock_quiet)
    else $error("outputs moved during lock");
  property p_osc_after_hold;
    $fell(oscEnable) |-> diffTrue == '0 && diffComp == '0 && seOut == '0;
  endproperty
  a_osc_after_hold: assert property (p_osc_after_hold)
    else $error("oscillator off before outputs held");
  property p_diff_down;
    (pinReady && !pins.supplyGoodPowerDownN) [*8] |->
      diffTrue == '0 && diffComp == '0;
  endproperty
  a_diff_down: assert property (p_diff_down)
    else $error("differential outputs not stopped low");
  property p_se_down;
    (pinReady && !pins.supplyGoodPowerDownN) [*8] |-> ##4 seOut == '0;
  endproperty
  a_se_down: assert property (p_se_down)
    else $error("single-ended outputs not held low");
  property p_park_still;
    (pllEnable && !pins.pairStopN) [*8] |=>
      $stable(diffTrue[3:2]) && $stable(diffComp[3:2]);
  endproperty
  a_park_still: assert property (p_park_still)
    else $error("stopped pair moved");
  property p_resume;
    $rose(pins.pairStopN) && diffTrue[2] && !diffComp[2] && pllEnable
      |-> ##[1:8] !diffTrue[2];
  endproperty
  a_resume: assert property (p_resume)
    else $error("stopped pair late to resume");
endmodule : cog_clock_control_chk
bind cog_clock_control cog_clock_control_chk #(
  .XTAL_STARTUP(XTAL_STARTUP),
  .DIFF_STARTUP(DIFF_STARTUP)
) chk (.clock(clock), .rstn(rstn), .pins(pins), .regAddr(regAddr),
  .regRdData(regRdData), .diffTrue(diffTrue), .diffComp(diffComp),
  .seOut(seOut), .oscEnable(oscEnable), .pllEnable(pllEnable),
  .pinReady(pinReady));

/* sim/cog_host_model.sv */
// Purpose: host side of the gating block, pins and raw clock phases
// Assumes: the bench sets pin levels just after a rising edge
// Notes:   phases free-run; the diff period is 2 cycles, single-ended 4
`timescale 1ns/1ps
module cog_host_model (
  input  wire logic                           clock,
  input  wire cog_pkg::cog_pins_t             hostPins,
  output cog_pkg::cog_pins_t                  pins,
  output logic [cog_pkg::DIFF_COUNT-1:0]      diffPhase,
  output logic [cog_pkg::SE_COUNT-1:0]        sePhase
);
  import cog_pkg::*;
  logic [1:0] phaseCnt = 2'h0;
  ////////////////////////////////////////////////////////////////////////
  // phases move just after the edge, as a real synthesizer output would
  always @(posedge clock) phaseCnt <= #1 phaseCnt + 2'h1;
  assign diffPhase = {DIFF_COUNT{phaseCnt[0]}};
  assign sePhase   = {SE_COUNT{phaseCnt[1]}};
  // pins are levels only; the device synchronises them
  assign pins = hostPins;
endmodule : cog_host_model

/* sim/tb_top.sv */
// Purpose: self-checking bench for the clock output gating block
// Assumes: short lock and startup counts set at the instance
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_top;
  import cog_pkg::*;
  logic               clock = 1'b0;
  logic               rstn = 1'b0;
  cog_pins_t          hostPins = 4'b0100;
  cog_pins_t          pins;
  logic [3:0]         diffPhase, diffTrue, diffComp;
  logic [2:0]         sePhase, seOut, seOutEn;
  logic [7:0]         regAddr = 8'h0, regWrData = 8'h0, regRdData;
  logic               regWrEn = 1'b0, oscEnable, pllEnable, pinReady;
  cog_slew_t          slew;
  logic [7:0]         d06, d0d;
  logic [1:0]         prev;
  int                 n_errors = 0, n_compared = 0, cycles = 0, n;
  int                 seed = 39792;
  initial forever #2 clock = ~clock;
  cog_host_model host (.clock(clock), .hostPins(hostPins), .pins(pins),
    .diffPhase(diffPhase), .sePhase(sePhase));
  cog_clock_control #(.LOCK_WAIT(20), .XTAL_STARTUP(10), .DIFF_STARTUP(30))
  uut (.clock(clock), .rstn(rstn), .pins(pins), .diffPhase(diffPhase),
    .sePhase(sePhase), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdData(regRdData), .diffTrue(diffTrue),
    .diffComp(diffComp), .seOut(seOut), .seOutEn(seOutEn),
    .oscEnable(oscEnable), .pllEnable(pllEnable), .pinReady(pinReady),
    .slew(slew));
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic check_vec(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_vec
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : cyc
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
    // one idle edge so a following write never re-raises the strobe at once
    cyc(1);
  endtask : reg_wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    cyc(1);
    check_vec({1'b0, regRdData}, {1'b0, exp});
  endtask : rd_chk
  // pair 0 never parks, so complementary legs mean the block runs
  task automatic wait_run();
    n = 0;
    while (diffTrue[0] === diffComp[0] && n < 100) begin
      cyc(1);
      n++;
    end
  endtask : wait_run
  function automatic logic [8:0] slew_exp(logic [7:0] m, logic [7:0] c);
    return {c[7], m[5], c[6], c[5], m[3], c[4], c[3], m[1], c[2]};
  endfunction : slew_exp
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    rstn = 1'b1;
    cyc(1);
    check_vec(slew, 9'h16d);
    rd_chk(PAIR_ENABLE_OFFSET, 8'h0c);
    rd_chk(SLEW_MID_OFFSET, 8'h00);
    rd_chk(SLEW_CONTROL_OFFSET, 8'hfc);
    reg_wr(IDENTITY_OFFSET, 8'h00);
    rd_chk(IDENTITY_OFFSET, {3'h5, FACTORY_PROGRAM_ID_DEFAULT});
    reg_wr(SLEW_CONTROL_OFFSET, 8'h01);
    cyc(1);
    check_vec(slew, 9'h1ff);
    rd_chk(SLEW_MID_OFFSET, 8'h2a);
    reg_wr(SLEW_CONTROL_OFFSET, 8'h00);
    cyc(1);
    check_vec(slew, 9'h16d);
    rd_chk(SLEW_CONTROL_OFFSET, 8'hfc);
    // low-emission bit kept clear, so every write stores its data
    repeat (8) begin
      d06 = 8'($random(seed)) & SLEW_MID_MASK;
      d0d = 8'($random(seed)) & 8'hfc;
      reg_wr(SLEW_MID_OFFSET, d06);
      reg_wr(SLEW_CONTROL_OFFSET, d0d);
      cyc(1);
      check_vec(slew, slew_exp(d06, d0d));
      rd_chk(SLEW_CONTROL_OFFSET, d0d);
      rd_chk({1'b1, 7'($random(seed))}, 8'h00);
    end
    $display("test registers done");
    check_vec({7'h0, pinReady, pllEnable}, 9'h2);
    hostPins[3] = 1'b1;
    wait_run();
    check_vec({8'h0, n >= 20 && n <= 40}, 9'h1);
    check_vec({6'h0, seOutEn}, 9'h7);
    // single-ended output 0 must show both levels once released
    prev = 2'h0;
    repeat (8) begin
      cyc(1);
      prev = prev | {seOut[0], !seOut[0]};
    end
    check_vec({7'h0, prev}, 9'h3);
    $display("test startup done");
    hostPins[2] = 1'b0;
    cyc(10);
    check_vec({5'h0, diffTrue[3:2], diffComp[3:2]}, 9'hc);
    prev = diffTrue[1:0];
    cyc(1);
    check_vec({7'h0, diffTrue[1:0] ^ prev}, 9'h3);
    hostPins[2] = 1'b1;
    n = 0;
    while (diffTrue[2] !== 1'b0 && n < 20) begin
      cyc(1);
      n++;
    end
    check_vec({8'h0, n <= 8}, 9'h1);
    repeat (4) begin
      prev = diffTrue[3:2];
      cyc(1);
      check_vec({7'h0, diffTrue[3:2] ^ prev}, 9'h3);
    end
    reg_wr(PAIR_ENABLE_OFFSET, 8'h00);
    cyc(3);
    check_vec({5'h0, diffTrue[3:2], diffComp[3:2]}, 9'h0);
    hostPins[2] = 1'b0;
    cyc(10);
    check_vec({5'h0, diffTrue[3:2], diffComp[3:2]}, 9'h0);
    check_vec({8'h0, diffTrue[0] ^ diffComp[0]}, 9'h1);
    hostPins[2] = 1'b1;
    reg_wr(PAIR_ENABLE_OFFSET, 8'h0c);
    cyc(4);
    $display("test pair stop done");
    // strap fitted first, then without it
    for (int s = 1; s >= 0; s--) begin
      hostPins[1] = s[0];
      hostPins[3] = 1'b0;
      cyc(12);
      check_vec({1'h0, diffTrue, diffComp}, 9'h0);
      check_vec({6'h0, seOut}, 9'h0);
      n = 0;
      while (oscEnable !== 1'b0 && n < 50) begin
        cyc(1);
        n++;
      end
      check_vec({7'h0, oscEnable, pllEnable}, 9'h0);
      check_vec({6'h0, seOutEn}, s[0] ? 9'h0 : 9'h7);
      hostPins[3] = 1'b1;
      wait_run();
      check_vec({8'h0, n <= 40}, 9'h1);
    end
    $display("test power down done");
    // mid-run reset with a differential reference: the longer startup
    hostPins = 4'b0101;
    rstn = 1'b0;
    cyc(20);
    rstn = 1'b1;
    cyc(20);
    check_vec({7'h0, pinReady, pllEnable}, 9'h0);
    cyc(12);
    check_vec({7'h0, pinReady, pllEnable}, 9'h2);
    $display("test second reset done");
    print_verdict();
  end
endmodule : tb_top
